// *** hw/read_line_buffer_pkg.sv ***
/*
  Package for the DMA read line buffer stage: address split, buffer count,
  port structs and the fetch state encoding.
  Assumes a 32-bit byte address and a 32-bit (one word) memory bus beat.
*/
package read_line_buffer_pkg;

  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LINE_BYTES = 32;
  localparam int unsigned OFF_W      = 5;                 // Byte offset in a block
  localparam int unsigned TAG_W      = ADDR_W - OFF_W;
  localparam int unsigned NUM_BUF    = 4;
  localparam int unsigned BUF_IDX_W  = 2;
  localparam int unsigned WORDS      = LINE_BYTES / 4;    // Words per block
  localparam int unsigned WIDX_W     = 3;
  localparam int unsigned WORD_LSB   = 2;                 // First word-select bit
  localparam logic [WIDX_W-1:0] LAST_WORD = 3'h7;
  localparam logic [1:0]        ALIGN_ZERO = 2'h0;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } dma_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
    logic              misaligned;  // Word address was not word aligned
  } dma_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;        // Block-aligned burst start
  } mem_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } mem_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_FILL  = 2'b10,
    ST_REPLY = 2'b11
  } fetch_state_t;

endpackage

// *** hw/read_line_buffer.sv ***
/*
  DMA read line buffer stage: four block buffers between the DMA engine
  and the system memory bus, with the known lack of snoop invalidation.
  Assumes one clock for both sides, a memory bus that accepts a burst
  request with mem_req_ready_i and then returns eight words in order on
  mem_rsp_i.valid, and a DMA engine that holds its request until answered.
*/
`timescale 1ns/10ps

module read_line_buffer
(
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire read_line_buffer_pkg::dma_req_t    dma_req_i,
  output logic                                   dma_req_ready_o,
  output read_line_buffer_pkg::dma_rsp_t         dma_rsp_o,
  output read_line_buffer_pkg::mem_req_t         mem_req_o,
  input  wire logic                              mem_req_ready_i,
  input  wire read_line_buffer_pkg::mem_rsp_t    mem_rsp_i,
  output logic [read_line_buffer_pkg::NUM_BUF-1:0] buf_valid_o
);

  localparam int unsigned NB = read_line_buffer_pkg::NUM_BUF;
  localparam int unsigned TW = read_line_buffer_pkg::TAG_W;
  localparam int unsigned DW = read_line_buffer_pkg::DATA_W;
  localparam int unsigned WN = read_line_buffer_pkg::WORDS;

  typedef struct packed {
    read_line_buffer_pkg::fetch_state_t                  state;
    logic [NB-1:0]                                       valid;
    logic [NB-1:0][TW-1:0]                               tag;
    logic [NB-1:0][WN-1:0][DW-1:0]                       data;
    logic [read_line_buffer_pkg::BUF_IDX_W-1:0]          victim;   // Oldest fill
    logic [read_line_buffer_pkg::BUF_IDX_W-1:0]          sel;
    logic [read_line_buffer_pkg::WIDX_W-1:0]             widx;
    read_line_buffer_pkg::dma_rsp_t                      rsp;
    read_line_buffer_pkg::mem_req_t                      mreq;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ---------------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------------
  function automatic logic [TW-1:0] tag_of(input logic [read_line_buffer_pkg::ADDR_W-1:0] a);
    tag_of = a[read_line_buffer_pkg::ADDR_W-1:read_line_buffer_pkg::OFF_W];
  endfunction

  function automatic logic [read_line_buffer_pkg::WIDX_W-1:0] word_of(
    input logic [read_line_buffer_pkg::ADDR_W-1:0] a);
    word_of = a[read_line_buffer_pkg::OFF_W-1:read_line_buffer_pkg::WORD_LSB];
  endfunction

  // ---------------------------------------------------------------------
  // Hit detection, one comparator per buffer
  // ---------------------------------------------------------------------
  logic [NB-1:0] hit_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_cmp
      // Tag only: no snoop port exists, so stale data still hits
      assign hit_vec[gi] = state_r.valid[gi] &&
                           (state_r.tag[gi] == tag_of(dma_req_i.addr));
    end
  endgenerate

  logic                                       hit;
  logic [read_line_buffer_pkg::BUF_IDX_W-1:0] hit_idx;

  // Only the buffer of the previous read may answer; a jump to any other
  // block refetches, even if another buffer still holds that block
  always_comb
  begin
    hit     = hit_vec[state_r.sel];
    hit_idx = state_r.sel;
  end

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb
  begin
    state_nxt           = state_r;
    state_nxt.rsp.valid = 1'b0;
    unique case (state_r.state)
      read_line_buffer_pkg::ST_IDLE:
      begin
        if (dma_req_i.valid)
        begin
          if (hit)
          begin
            // Served from the buffer, no bus traffic
            state_nxt.sel   = hit_idx;
            state_nxt.state = read_line_buffer_pkg::ST_REPLY;
          end
          else
          begin
            // Whole block burst into the oldest buffer
            state_nxt.sel            = state_r.victim;
            // Drop any older copy of this block so a tag lives in one buffer
            state_nxt.valid          = state_r.valid & ~hit_vec;
            state_nxt.valid[state_r.victim] = 1'b0;
            state_nxt.mreq.valid     = 1'b1;
            state_nxt.mreq.addr      = {tag_of(dma_req_i.addr),
                                        {read_line_buffer_pkg::OFF_W{1'b0}}};
            state_nxt.state          = read_line_buffer_pkg::ST_FETCH;
          end
        end
      end
      read_line_buffer_pkg::ST_FETCH:
      begin
        if (mem_req_ready_i)
        begin
          state_nxt.mreq.valid = 1'b0;
          state_nxt.widx       = '0;
          state_nxt.state      = read_line_buffer_pkg::ST_FILL;
        end
      end
      read_line_buffer_pkg::ST_FILL:
      begin
        if (mem_rsp_i.valid)
        begin
          state_nxt.data[state_r.sel][state_r.widx] = mem_rsp_i.data;
          state_nxt.widx = state_r.widx + 1'b1;
          if (state_r.widx == read_line_buffer_pkg::LAST_WORD)
          begin
            state_nxt.valid[state_r.sel] = 1'b1;
            state_nxt.tag[state_r.sel]   = tag_of(dma_req_i.addr);
            state_nxt.victim             = state_r.victim + 1'b1;
            state_nxt.state              = read_line_buffer_pkg::ST_REPLY;
          end
        end
      end
      read_line_buffer_pkg::ST_REPLY:
      begin
        // Misaligned word address is not fixed up here, only reported
        state_nxt.rsp.valid      = 1'b1;
        state_nxt.rsp.data       = state_r.data[state_r.sel][word_of(dma_req_i.addr)];
        state_nxt.rsp.misaligned = dma_req_i.addr[read_line_buffer_pkg::WORD_LSB-1:0]
                                   != read_line_buffer_pkg::ALIGN_ZERO;
        state_nxt.state          = read_line_buffer_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Request accepted on the cycle the answer is registered
  assign dma_req_ready_o = (state_r.state == read_line_buffer_pkg::ST_REPLY);
  assign dma_rsp_o       = state_r.rsp;
  assign mem_req_o       = state_r.mreq;
  assign buf_valid_o     = state_r.valid;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  hit_no_fetch_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_IDLE) && dma_req_i.valid && hit
    |=> !mem_req_o.valid ##1 dma_rsp_o.valid)
    else $error("buffer hit caused a fetch");

  miss_fetch_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_IDLE) && dma_req_i.valid && !hit
    |=> mem_req_o.valid && (mem_req_o.addr[read_line_buffer_pkg::OFF_W-1:0] == '0))
    else $error("miss without aligned block fetch");

  fill_count_a: assert property (
    $rose(state_r.state == read_line_buffer_pkg::ST_FILL)
    |-> state_r.widx == '0)
    else $error("fill did not start at word zero");

  fill_valid_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_FILL) && mem_rsp_i.valid &&
    (state_r.widx == read_line_buffer_pkg::LAST_WORD)
    |=> buf_valid_o[$past(state_r.sel)] && $countones(buf_valid_o) >= 1)
    else $error("filled buffer not marked valid");

  victim_step_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_FILL) && mem_rsp_i.valid &&
    (state_r.widx == read_line_buffer_pkg::LAST_WORD)
    |=> state_r.victim == $past(state_r.victim) + 2'h1)
    else $error("replacement pointer did not advance");

  miss_evict_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_IDLE) && dma_req_i.valid && !hit
    |=> !buf_valid_o[$past(state_r.victim)])
    else $error("replaced buffer still valid during fetch");

  copy_drop_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_IDLE) && dma_req_i.valid && !hit
    |=> (buf_valid_o & $past(hit_vec)) == '0)
    else $error("older copy of refetched block kept");

  misalign_flag_a: assert property (
    (state_r.state == read_line_buffer_pkg::ST_REPLY)
    |=> dma_rsp_o.misaligned == ($past(dma_req_i.addr[1:0]) != 2'h0))
    else $error("misaligned flag wrong");

  one_hit_a: assert property (
    $onehot0(hit_vec))
    else $error("address hit more than one buffer");

  hit_c:   cover property ((state_r.state == read_line_buffer_pkg::ST_IDLE) &&
                           dma_req_i.valid && hit);
  miss_c:  cover property ((state_r.state == read_line_buffer_pkg::ST_IDLE) &&
                           dma_req_i.valid && !hit);
  full_c:  cover property (&buf_valid_o);
  unal_c:  cover property (dma_rsp_o.valid && dma_rsp_o.misaligned);

endmodule // read_line_buffer

// *** verification/mem_bus_model.sv ***
/*
  Memory bus partner: accepts one block burst at a time, returns eight words.
  Assumes block-aligned burst requests held until accepted.
*/
`timescale 1ns/10ps
module mem_bus_model
(
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire read_line_buffer_pkg::mem_req_t mem_req_i,
  input  wire logic                           slow_i,
  input  wire logic [15:0]                    gen_i,
  output logic                                mem_req_ready_o,
  output read_line_buffer_pkg::mem_rsp_t      mem_rsp_o,
  output int                                  fetches_o
);
  logic        busy_r;
  logic        ph_r;
  logic [2:0]  beat_r;
  logic [31:0] base_r;
  // ---------------------------------------------------------------
  // Burst engine
  // ---------------------------------------------------------------
  // Slow mode only acts on alternate cycles, stretching accept and beats
  always @(posedge clk_i)
  begin
    mem_req_ready_o <= 1'b0;
    mem_rsp_o.valid <= 1'b0;
    mem_rsp_o.data  <= ~mem_rsp_o.data;  // Idle bus inverts every data bit each cycle, so the last word returns every other cycle
    ph_r            <= ~ph_r;
    if (!rst_n_i)
    begin
      busy_r         <= 1'b0;
      ph_r           <= 1'b0;  // Phase must be known or slow mode never acts
      beat_r         <= 3'h0;
      fetches_o      <= 0;
      mem_rsp_o.data <= 32'h0000_0000;
    end
    else if (!busy_r && mem_req_i.valid && !mem_req_ready_o && (ph_r || !slow_i))
    begin
      mem_req_ready_o <= 1'b1;
      busy_r          <= 1'b1;
      base_r          <= mem_req_i.addr;
      fetches_o       <= fetches_o + 1;
    end
    else if (busy_r && !mem_req_ready_o && (ph_r || !slow_i))
    begin
      mem_rsp_o.valid <= 1'b1;
      mem_rsp_o.data  <= {gen_i, base_r[15:0] + {11'h000, beat_r, 2'h0}};
      beat_r          <= beat_r + 3'h1;
      busy_r          <= (beat_r != 3'h7);
    end
  end
endmodule // mem_bus_model

// *** verification/tb.sv ***
/*
  Testbench for the read line buffer: hand-written scenarios.
  Assumes the memory model in mem_bus_model and the port timing of the stage.
*/
`timescale 1ns/10ps
module tb;
  logic                                       clk_i;
  logic                                       rst_n_i;
  read_line_buffer_pkg::dma_req_t             dma_req;
  logic                                       dma_ready;
  read_line_buffer_pkg::dma_rsp_t             dma_rsp;
  read_line_buffer_pkg::mem_req_t             mem_req;
  logic                                       mem_ready;
  read_line_buffer_pkg::mem_rsp_t             mem_rsp;
  logic [read_line_buffer_pkg::NUM_BUF-1:0]   buf_valid;
  logic                                       slow;
  logic [15:0]                                gen;
  int                                         fetches;
  int                                         err_total;
  int                                         total_checks;
  // ---------------------------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  read_line_buffer dut_u
  (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .dma_req_i       (dma_req),
    .dma_req_ready_o (dma_ready),
    .dma_rsp_o       (dma_rsp),
    .mem_req_o       (mem_req),
    .mem_req_ready_i (mem_ready),
    .mem_rsp_i       (mem_rsp),
    .buf_valid_o     (buf_valid)
  );
  mem_bus_model mem_u
  (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .mem_req_i       (mem_req),
    .slow_i          (slow),
    .gen_i           (gen),
    .mem_req_ready_o (mem_ready),
    .mem_rsp_o       (mem_rsp),
    .fetches_o       (fetches)
  );
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bursts always start on a block boundary; sampled away from the launching edge
  always @(negedge clk_i)
    if (mem_req.valid === 1'b1)
      chk(mem_req.addr[4:0] === 5'h00, "burst not block aligned");
  // Reset held three cycles; everything must come up empty
  task automatic do_reset;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk({buf_valid, dma_rsp.valid, mem_req.valid, dma_ready} === 7'h00, "reset state");
  endtask
  // One DMA read; judges data, flag and the bursts it caused
  task automatic rd(input logic [31:0] a, input logic [15:0] g, input int nf);
    int f0;
    int n;
    f0 = fetches;
    n = 0;
    dma_req.valid = 1'b1;
    dma_req.addr  = a;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (dma_ready !== 1'b1 && n < 200);
    chk(n < 200, "no ready");
    @(posedge clk_i);
    #1;
    dma_req.valid = 1'b0;
    chk(dma_rsp.valid === 1'b1, "no response");
    chk(dma_rsp.data === {g, a[15:2], 2'h0}, "wrong data");
    chk(dma_rsp.misaligned === (a[1:0] != 2'h0), "wrong align flag");
    chk(fetches - f0 == nf, "wrong fetch count");
    @(posedge clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_hits;
    rd(32'h0000_2340, 16'h0001, 1);
    rd(32'h0000_2344, 16'h0001, 0);
    rd(32'h0000_235C, 16'h0001, 0);
    chk(buf_valid === 4'h1, "one buffer held");
  endtask
  // Another master rewrites memory; the held copy is still served
  task automatic t_stale;
    gen = 16'h0002;
    rd(32'h0000_2348, 16'h0001, 0);
  endtask
  // Spaced blocks in reverse order with a slow memory fill all four
  task automatic t_evict;
    slow = 1'b1;
    rd(32'h0000_2700, 16'h0002, 1);
    rd(32'h0000_2600, 16'h0002, 1);
    rd(32'h0000_2500, 16'h0002, 1);
    chk(buf_valid === 4'hF, "four buffers held");
    rd(32'h0000_2800, 16'h0002, 1);
    slow = 1'b0;
    rd(32'h0000_2344, 16'h0002, 1);
    rd(32'h0000_2504, 16'h0002, 1);
    chk(buf_valid === 4'h7, "older copy dropped");
    rd(32'h0000_2704, 16'h0002, 1);
    chk(buf_valid === 4'hF, "four buffers refilled");
  endtask
  task automatic t_misalign;
    rd(32'h0000_2806, 16'h0002, 1);
  endtask
  initial
  begin
    err_total     = 0;
    total_checks  = 0;
    rst_n_i       = 1'b0;
    dma_req       = '0;
    slow          = 1'b0;
    gen           = 16'h0001;
    do_reset();
    t_hits();
    t_stale();
    t_evict();
    t_misalign();
    do_reset();
    rd(32'h0000_2344, 16'h0002, 1);
    tally_and_finish();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule // tb
